// ### design/sar_regs.vh
// Purpose: register map, fields and constants of the SDRAM refresh block
// Assumes: AXI4-Lite, 32-bit words, byte addresses
// Notes: include by bare name
`ifndef SAR_REGS_VH
`define SAR_REGS_VH
// Offsets
`define SAR_OFF_A2WC 5'h00
`define SAR_OFF_A3WC 5'h04
`define SAR_OFF_SDC 5'h08
`define SAR_OFF_RTCS 5'h0C
`define SAR_OFF_RCNT 5'h10
`define SAR_OFF_RCMP 5'h14
`define SAR_OFF_STAT 5'h18
// Area 2 wait control fields
`define SAR_A2_CL_LO 7
`define SAR_A2_CL_HI 8
`define SAR_A2_ONE_BIT 10
`define SAR_A2_CL_RST 2'h2
// Area 3 wait control fields
`define SAR_A3_TRP_LO 0
`define SAR_A3_TRP_HI 1
`define SAR_A3_TRC_LO 2
`define SAR_A3_TRC_HI 3
`define SAR_A3_TRP_RST 2'h1
`define SAR_A3_TRC_RST 2'h3
// SDRAM control fields
`define SAR_SDC_EN_BIT 0
`define SAR_SDC_MODE_BIT 1
// Timer control fields
`define SAR_RT_CKS_LO 0
`define SAR_RT_CKS_HI 2
`define SAR_RT_RRC_LO 3
`define SAR_RT_RRC_HI 5
// Widths
`define SAR_CNT_W 8
`define SAR_PRE_W 12
// SDRAM commands
`define SAR_CMD_NOP 2'h0
`define SAR_CMD_PALL 2'h1
`define SAR_CMD_REF 2'h2
// AXI responses
`define SAR_RESP_OKAY 2'h0
`define SAR_RESP_SLVERR 2'h2
`endif

// ### design/sar_prescaler.v
// Purpose: refresh counter clock prescaler, one-cycle tick per selected period
// Assumes: select 0 stops the tick
// Notes: select 1..7 divide by 4,16,64,256,1024,2048,4096
`timescale 1ns/1ns
`include "sar_regs.vh"
module sar_prescaler (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Control
  input wire [2:0] clk_sel,
  // Tick
  output reg tick_q
);
  reg [`SAR_PRE_W-1:0] pre_q;
  reg [`SAR_PRE_W-1:0] mask;

  always @* begin
    case (clk_sel)
      3'h1: mask = 12'h003;
      3'h2: mask = 12'h00F;
      3'h3: mask = 12'h03F;
      3'h4: mask = 12'h0FF;
      3'h5: mask = 12'h3FF;
      3'h6: mask = 12'h7FF;
      3'h7: mask = 12'hFFF;
      default: mask = 12'h000;
    endcase
  end

  // Free-running, so a new select takes effect without clearing anything
  always @(posedge core_clk) begin
    if (srst) begin
      pre_q <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 12'h001;
      tick_q <= (clk_sel != 3'h0) && ((pre_q & mask) == mask);
    end
  end
endmodule // sar_prescaler

// ### design/sar_refresh_ctrl.v
// Purpose: area 2 CAS latency register and SDRAM auto-refresh engine
// Assumes: AXI4-Lite slave, one clock, synchronous reset
// Notes: sdram_cmd_q holds NOP when no refresh command is due
//
// Overview of operation
// - Bits 8:7 of the area 2 wait register pick CAS latency 1 to 4 cycles, reset 10.
// - Bit 10 of the area 2 wait register reads one, other reserved bits read zero.
// - Refresh interval follows the selected counter clock and the compare constant.
// - Selecting a counter clock lets the counter run on from its present value.
// - A counter equal to the constant requests refresh, repeated as the repeat count says.
// - On that match the counter clears to zero and keeps counting.
// - Each auto-refresh opens with a precharge-all command in the precharge cycle.
// - After the precharge cycle come the programmed idle cycles, then the refresh command.
// - One or more idle cycles sit between precharge and refresh when the wait is nonzero.
// - After refresh no new command is issued for the programmed recovery cycles.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "sar_regs.vh"
module sar_refresh_ctrl (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [4:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [4:0] s_axi_araddr,
  // AXI4-Lite read data
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // SDRAM side
  output reg [1:0] sdram_cmd_q,
  output reg sdram_cmd_hold_q,
  output reg refresh_req_q,
  output reg [1:0] area2_column_latency_q
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PALL = 3'h1;
  localparam ST_PWAIT = 3'h2;
  localparam ST_REF = 3'h3;
  localparam ST_RECOV = 3'h4;

  // Register state
  reg [1:0] precharge_wait_field_q;
  reg [1:0] refresh_recovery_field_q;
  reg refresh_enable_bit_q;
  reg refresh_mode_bit_q;
  reg [2:0] refresh_clock_select_q;
  reg [2:0] refresh_repeat_count_q;
  reg [`SAR_CNT_W-1:0] refresh_counter_q;
  reg [`SAR_CNT_W-1:0] refresh_compare_constant_q;
  // Engine state
  reg [2:0] state_q;
  reg [1:0] wait_q;
  reg [3:0] pend_q;
  reg [3:0] pend_d;
  reg [4:0] pend_sum;
  // Bus state
  reg aw_have_q;
  reg w_have_q;
  reg [4:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rd_mux;
  reg rd_ok;
  wire tick;
  wire do_write;
  wire match;
  wire wr_cnt;

  sar_prescaler u_pre (
    .core_clk(core_clk),
    .srst(srst),
    .clk_sel(refresh_clock_select_q),
    .tick_q(tick)
  );

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_cnt = do_write && (awaddr_q == `SAR_OFF_RCNT) && wstrb_q[0];
  // Match only while auto-refresh is on; self-refresh mode suppresses it
  assign match = refresh_enable_bit_q && !refresh_mode_bit_q &&
                 (refresh_counter_q == refresh_compare_constant_q);

  // Write channel: address and data accepted in either order
  always @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAR_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_q <= `SAR_OFF_STAT && awaddr_q[1:0] == 2'h0) begin
          s_axi_bresp <= `SAR_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SAR_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable fields; reserved bits are simply not stored
  always @(posedge core_clk) begin
    if (srst) begin
      area2_column_latency_q <= `SAR_A2_CL_RST;
      precharge_wait_field_q <= `SAR_A3_TRP_RST;
      refresh_recovery_field_q <= `SAR_A3_TRC_RST;
      refresh_enable_bit_q <= 1'b0;
      refresh_mode_bit_q <= 1'b0;
      refresh_clock_select_q <= 3'h0;
      refresh_repeat_count_q <= 3'h0;
      refresh_compare_constant_q <= 8'h00;
    end else if (do_write) begin
      case (awaddr_q)
        `SAR_OFF_A2WC: begin
          if (wstrb_q[0]) begin
            area2_column_latency_q[0] <= wdata_q[`SAR_A2_CL_LO];
          end
          if (wstrb_q[1]) begin
            area2_column_latency_q[1] <= wdata_q[`SAR_A2_CL_HI];
          end
        end
        `SAR_OFF_A3WC: begin
          if (wstrb_q[0]) begin
            precharge_wait_field_q <= wdata_q[`SAR_A3_TRP_HI:`SAR_A3_TRP_LO];
            refresh_recovery_field_q <= wdata_q[`SAR_A3_TRC_HI:`SAR_A3_TRC_LO];
          end
        end
        `SAR_OFF_SDC: begin
          if (wstrb_q[0]) begin
            refresh_enable_bit_q <= wdata_q[`SAR_SDC_EN_BIT];
            refresh_mode_bit_q <= wdata_q[`SAR_SDC_MODE_BIT];
          end
        end
        `SAR_OFF_RTCS: begin
          if (wstrb_q[0]) begin
            refresh_clock_select_q <= wdata_q[`SAR_RT_CKS_HI:`SAR_RT_CKS_LO];
            refresh_repeat_count_q <= wdata_q[`SAR_RT_RRC_HI:`SAR_RT_RRC_LO];
          end
        end
        `SAR_OFF_RCMP: begin
          if (wstrb_q[0]) begin
            refresh_compare_constant_q <= wdata_q[`SAR_CNT_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Refresh counter: a software write wins over a tick or a match
  always @(posedge core_clk) begin
    if (srst) begin
      refresh_counter_q <= 8'h00;
    end else if (wr_cnt) begin
      refresh_counter_q <= wdata_q[`SAR_CNT_W-1:0];
    end else if (match && tick) begin
      refresh_counter_q <= 8'h00;
    end else if (tick) begin
      refresh_counter_q <= refresh_counter_q + 8'h01;
    end
  end

  // Pending refresh count: a match adds repeat count plus one
  always @* begin
    pend_sum = {1'b0, pend_q};
    if (match && tick && !wr_cnt) begin
      pend_sum = pend_sum + {2'h0, refresh_repeat_count_q} + 5'h01;
    end
    if (state_q == ST_REF) begin
      pend_sum = pend_sum - 5'h01;
    end
    // Saturates rather than wraps if requests pile up
    if (pend_sum[4]) begin
      pend_d = 4'hF;
    end else begin
      pend_d = pend_sum[3:0];
    end
  end

  // Refresh sequencer
  always @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      wait_q <= 2'h0;
      pend_q <= 4'h0;
      sdram_cmd_q <= `SAR_CMD_NOP;
      sdram_cmd_hold_q <= 1'b0;
      refresh_req_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      refresh_req_q <= match && tick && !wr_cnt;
      case (state_q)
        ST_IDLE: begin
          if (pend_q != 4'h0) begin
            state_q <= ST_PALL;
            sdram_cmd_q <= `SAR_CMD_PALL;
            sdram_cmd_hold_q <= 1'b1;
          end else begin
            sdram_cmd_q <= `SAR_CMD_NOP;
            sdram_cmd_hold_q <= 1'b0;
          end
        end
        ST_PALL: begin
          if (precharge_wait_field_q == 2'h0) begin
            state_q <= ST_REF;
            sdram_cmd_q <= `SAR_CMD_REF;
          end else begin
            state_q <= ST_PWAIT;
            sdram_cmd_q <= `SAR_CMD_NOP;
            wait_q <= precharge_wait_field_q - 2'h1;
          end
        end
        ST_PWAIT: begin
          if (wait_q == 2'h0) begin
            state_q <= ST_REF;
            sdram_cmd_q <= `SAR_CMD_REF;
          end else begin
            wait_q <= wait_q - 2'h1;
          end
        end
        ST_REF: begin
          state_q <= ST_RECOV;
          sdram_cmd_q <= `SAR_CMD_NOP;
          wait_q <= refresh_recovery_field_q;
        end
        ST_RECOV: begin
          // Hold stays up so no other command slips in
          if (wait_q == 2'h0) begin
            state_q <= ST_IDLE;
          end else begin
            wait_q <= wait_q - 2'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          sdram_cmd_q <= `SAR_CMD_NOP;
          sdram_cmd_hold_q <= 1'b0;
        end
      endcase
    end
  end

  // Read decode
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `SAR_OFF_A2WC: begin
        rd_mux[`SAR_A2_ONE_BIT] = 1'b1;
        rd_mux[`SAR_A2_CL_HI:`SAR_A2_CL_LO] = area2_column_latency_q;
      end
      `SAR_OFF_A3WC: begin
        rd_mux[`SAR_A3_TRP_HI:`SAR_A3_TRP_LO] = precharge_wait_field_q;
        rd_mux[`SAR_A3_TRC_HI:`SAR_A3_TRC_LO] = refresh_recovery_field_q;
      end
      `SAR_OFF_SDC: begin
        rd_mux[`SAR_SDC_EN_BIT] = refresh_enable_bit_q;
        rd_mux[`SAR_SDC_MODE_BIT] = refresh_mode_bit_q;
      end
      `SAR_OFF_RTCS: begin
        rd_mux[`SAR_RT_CKS_HI:`SAR_RT_CKS_LO] = refresh_clock_select_q;
        rd_mux[`SAR_RT_RRC_HI:`SAR_RT_RRC_LO] = refresh_repeat_count_q;
      end
      `SAR_OFF_RCNT: begin
        rd_mux[`SAR_CNT_W-1:0] = refresh_counter_q;
      end
      `SAR_OFF_RCMP: begin
        rd_mux[`SAR_CNT_W-1:0] = refresh_compare_constant_q;
      end
      `SAR_OFF_STAT: begin
        rd_mux[2:0] = state_q;
        rd_mux[7:4] = pend_q;
        rd_mux[8] = sdram_cmd_hold_q;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read channel: one outstanding read, answer one cycle after acceptance
  always @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SAR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `SAR_RESP_OKAY : `SAR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // sar_refresh_ctrl

// ### bench/sar_rc_assertions.sv
// Purpose: port checks on refresh command timing and latency field
// Assumes: area 3 waits stay at reset (precharge 1, recovery 3)
// Notes: bound to the refresh block below
`timescale 1ns/1ns
`include "sar_regs.vh"
module sar_rc_assertions (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Observed outputs
  input wire s_axi_bvalid,
  input wire [1:0] sdram_cmd_q,
  input wire sdram_cmd_hold_q,
  input wire refresh_req_q,
  input wire [1:0] area2_column_latency_q
);
  wire pall = sdram_cmd_q == `SAR_CMD_PALL;
  wire rf = sdram_cmd_q == `SAR_CMD_REF;
  wire nop = sdram_cmd_q == `SAR_CMD_NOP;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_pall_hold;
    pall |-> sdram_cmd_hold_q;
  endproperty
  a_pall_hold: assert property (p_pall_hold) else $error("precharge without hold");
  property p_pall_idle;
    pall |=> nop ##1 rf;
  endproperty
  a_pall_idle: assert property (p_pall_idle) else $error("bad idle before refresh");
  property p_pall_gap;
    pall |=> !rf;
  endproperty
  a_pall_gap: assert property (p_pall_gap) else $error("refresh right after precharge");
  property p_rec;
    rf |=> (nop && sdram_cmd_hold_q) [*4];
  endproperty
  a_rec: assert property (p_rec) else $error("command inside recovery");
  property p_rec_end;
    $fell(sdram_cmd_hold_q) |-> nop && $past(sdram_cmd_q, 6) == `SAR_CMD_REF;
  endproperty
  a_rec_end: assert property (p_rec_end) else $error("recovery length wrong");
  property p_req_pulse;
    refresh_req_q |=> !refresh_req_q;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request not one cycle");
  property p_req_pall;
    refresh_req_q && !sdram_cmd_hold_q |-> ##[1:4] pall;
  endproperty
  a_req_pall: assert property (p_req_pall) else $error("no precharge after request");
  property p_lat;
    $changed(area2_column_latency_q) |-> $rose(s_axi_bvalid);
  endproperty
  a_lat: assert property (p_lat) else $error("latency moved without write");
  c_pall: cover property (pall);
  c_req: cover property (refresh_req_q);
  c_lat: cover property ($changed(area2_column_latency_q));
endmodule // sar_rc_assertions

bind sar_refresh_ctrl sar_rc_assertions u_chk (
  .core_clk(core_clk),
  .srst(srst),
  .s_axi_bvalid(s_axi_bvalid),
  .sdram_cmd_q(sdram_cmd_q),
  .sdram_cmd_hold_q(sdram_cmd_hold_q),
  .refresh_req_q(refresh_req_q),
  .area2_column_latency_q(area2_column_latency_q)
);

// ### bench/sar_sdram_model.sv
// Purpose: far-side memory, counts commands and flags misuse
// Assumes: recovery 3 leaves four quiet cycles after refresh
// Notes: counters only grow; bench compares deltas
`timescale 1ns/1ns
`include "sar_regs.vh"
module sar_sdram_model (
  // Clock
  input wire core_clk,
  // Command in
  input wire [1:0] sdram_cmd_q,
  // Status out
  output reg [7:0] n_pall,
  output reg [7:0] n_ref,
  output reg bad
);
  reg open_q;
  integer gap;
  initial begin
    n_pall = 8'h00;
    n_ref = 8'h00;
    bad = 1'b0;
    open_q = 1'b0;
    gap = 9;
  end
  always @(posedge core_clk) begin
    gap <= gap + 1;
    if (sdram_cmd_q != `SAR_CMD_NOP && gap < 4) bad <= 1'b1;
    if (sdram_cmd_q == `SAR_CMD_PALL) begin
      n_pall <= n_pall + 8'h01;
      open_q <= 1'b1;
    end
    if (sdram_cmd_q == `SAR_CMD_REF) begin
      n_ref <= n_ref + 8'h01;
      gap <= 0;
      open_q <= 1'b0;
      if (!open_q) bad <= 1'b1;
    end
  end
endmodule // sar_sdram_model

// ### bench/sar_refresh_ctrl_bench.sv
// Purpose: self-checking bench of the refresh block
// Assumes: reset values of area 3 waits
// Notes: bus answers are checked from a queue
`timescale 1ns/1ns
`include "sar_regs.vh"
module sar_refresh_ctrl_bench;
  reg core_clk, srst, awv, wv, bry, arv, rry;
  reg [4:0] awa, ara;
  reg [31:0] wd, v;
  wire awr, wrd, bv, arr, rv, hold, req, bad;
  wire [1:0] br, rr, cmd, lat;
  wire [31:0] rdt;
  wire [7:0] np, nr;
  reg [7:0] sp, sr;
  integer n_mismatch, checks, seed, n, c;
  reg [33:0] exp_q[$];
  sar_refresh_ctrl u_dut (.core_clk(core_clk), .srst(srst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdt), .s_axi_rresp(rr),
    .sdram_cmd_q(cmd), .sdram_cmd_hold_q(hold), .refresh_req_q(req),
    .area2_column_latency_q(lat));
  sar_sdram_model u_mem (.core_clk(core_clk), .sdram_cmd_q(cmd), .n_pall(np), .n_ref(nr),
    .bad(bad));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input [33:0] got, input [33:0] want);
    begin
      checks = checks + 1;
      if (got !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task close_out;
    begin
      if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // A hang ends the run here rather than in the main flow
  task tmo(input integer k);
    if (k >= 300) begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  endtask
  task wr(input [4:0] a, input [31:0] d, input [1:0] r);
    integer k;
    begin
      exp_q.push_back({r, 32'h0});
      awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; bry <= 1'b1;
      k = 0;
      do begin
        @(posedge core_clk);
        k = k + 1;
        if (awr) awv <= 1'b0;
        if (wrd) wv <= 1'b0;
      end while (!bv && k < 300);
      bry <= 1'b0;
      tmo(k);
      // One edge apart so back-to-back calls never drive bready twice at once
      @(posedge core_clk);
    end
  endtask
  task rd(input [4:0] a, input [31:0] d, input [1:0] r);
    integer k;
    begin
      exp_q.push_back({r, d});
      arv <= 1'b1; ara <= a; rry <= 1'b1;
      k = 0;
      do begin
        @(posedge core_clk);
        k = k + 1;
        if (arr) arv <= 1'b0;
      end while (!rv && k < 300);
      rry <= 1'b0;
      tmo(k);
      @(posedge core_clk);
    end
  endtask
  task wreq(output integer m);
    begin
      m = 0;
      do begin
        @(posedge core_clk);
        m = m + 1;
      end while (!req && m < 300);
      tmo(m);
    end
  endtask
  always @(posedge core_clk) begin
    if (bv && bry) chk({br, 32'h0}, exp_q.pop_front());
    if (rv && rry) chk({rr, rdt}, exp_q.pop_front());
  end
  initial begin
    seed = 32'h1cb0; n_mismatch = 0; checks = 0; srst = 1'b1;
    awv = 1'b0; wv = 1'b0; bry = 1'b0; arv = 1'b0; rry = 1'b0;
    awa = 5'h00; ara = 5'h00; wd = 32'h0;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(`SAR_OFF_A2WC, 32'h500, `SAR_RESP_OKAY);
    rd(`SAR_OFF_A3WC, 32'hD, `SAR_RESP_OKAY);
    for (c = 0; c < 4; c = c + 1) begin
      // Software keeps bit 10 at one and the other reserved bits at zero
      v = 32'h400 | (c << 7);
      wr(`SAR_OFF_A2WC, v, `SAR_RESP_OKAY);
      chk({32'h0, lat}, c[1:0]);
      rd(`SAR_OFF_A2WC, 32'h400 | (c << 7), `SAR_RESP_OKAY);
    end
    // Unmapped place refused both ways
    rd(5'h1C, 32'h0, `SAR_RESP_SLVERR);
    wr(5'h1C, $random(seed), `SAR_RESP_SLVERR);
    wr(`SAR_OFF_A3WC, 32'hD, `SAR_RESP_OKAY);
    wr(`SAR_OFF_RCMP, 32'd20, `SAR_RESP_OKAY);
    wr(`SAR_OFF_RCNT, 32'd5, `SAR_RESP_OKAY);
    wr(`SAR_OFF_SDC, 32'h1, `SAR_RESP_OKAY);
    rd(`SAR_OFF_RCNT, 32'd5, `SAR_RESP_OKAY);
    wr(`SAR_OFF_RTCS, 32'h9, `SAR_RESP_OKAY);
    // From 5: 16 ticks of 4 cycles; a cleared start would need about 84
    wreq(n);
    chk(n >= 50 && n <= 70, 34'h1);
    sp = np;
    sr = nr;
    wreq(n);
    // Match is taken on the tick after equality: constant plus one ticks
    chk(n, 34'd84);
    repeat (40) @(posedge core_clk);
    chk({18'h0, np - sp, nr - sr}, {18'h0, 8'd4, 8'd4});
    wr(`SAR_OFF_SDC, 32'h3, `SAR_RESP_OKAY);
    sp = np;
    repeat (200) @(posedge core_clk);
    chk(np - sp, 34'h0);
    chk(bad, 34'h0);
    close_out;
  end
endmodule // sar_refresh_ctrl_bench
